// ===== hw/octal_dac_control.sv
// Control core of an eight-channel converter driven by 32-bit serial command frames
//
// What this block does
// - Frame is 32 bits: 4 ignored, command, channel address, data field.
// - Frame select low starts a frame; bits taken on falling edges; run at 32nd.
// - Frame select rising before the 32nd edge drops the frame with no effect.
// - Write-update-all command writes one input register then copies all to outputs.
// - Command 0100 is power control with mode from bits 9 and 8.
// - Low eight bits select channels; only selected channels take the mode.
// - Modes: normal, 1k to ground, 100k to ground, high impedance.
// - Reference powers down only when all eight channels are powered down.
// - Power-down leaves the output registers untouched.
// - Power-up resumes from input register if load is low, else old output.
// - Clear strobe falling loads the clear code into all input and output registers.
// - Command 0101 loads the clear-code selection from bits 1 and 0.
// - Selection 00 zero, 01 mid, 10 full, 11 no clear; resets to 00.
// - Clear state holds until the 32nd edge of the next complete frame.
// - Clear strobe falling during a frame abandons that frame.
// - Reference set-up takes bit 0 as reference enable; off after reset.
// - Load low: written channel output updates when the frame executes.
// - Load high: only inputs change; load falling copies inputs to outputs.
// - Command 0110 loads the eight-bit override mask; resets to zero.
// - Override bit set: channel updates at once as if load were low.
`timescale 1ns/1ps
`include "dac_ctrl_params.svh"

module octal_dac_control
	import dac_ctrl_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic shift_clk_i,
	input wire logic frame_sel_n_i,
	input wire logic serial_data_i,
	input wire logic load_strobe_n_i,
	input wire logic clear_strobe_n_i,
	output code_type [7:0] output_code_o,
	output code_type [7:0] input_code_o,
	output power_mode_type [7:0] power_mode_o,
	output logic reference_on_o,
	output logic clear_active_o
);

	core_state_type q;
	core_state_type d;
	frame_type word;
	logic done_toggle;
	logic clear_fall;
	logic load_fall;
	logic frame_arrived;
	logic frame_execute;
	logic [7:0] addr_hit;
	logic [7:0] power_select;
	logic [7:0] direct_update;
	logic [7:0] powered_down;
	code_type frame_code;
	code_type clear_code;
	power_mode_type frame_mode;

	command_frame_receiver receiver (
		.resetn_i(resetn_i),
		.shift_clk_i(shift_clk_i),
		.frame_sel_n_i(frame_sel_n_i),
		.serial_data_i(serial_data_i),
		.word_o(word),
		.done_toggle_o(done_toggle)
	);

	// Word is stable from its toggle until the next frame completes, which
	// is a whole frame later, so reading it after the sync stages is safe
	assign frame_code = word.data[`CODE_FIELD_HI:`CODE_FIELD_LO];
	assign frame_mode = power_mode_type'(word.data[`MODE_FIELD_HI:`MODE_FIELD_LO]);

	assign clear_fall = q.clear_last & ~q.clear_sync;
	assign load_fall = q.load_last & ~q.load_sync;
	assign frame_arrived = q.done_sync ^ q.done_last;
	// A clear falling in the same cycle also kills the frame
	assign frame_execute = frame_arrived & ~q.abort & ~clear_fall;

	generate
		for (genvar n = 0; n < `CHANNEL_COUNT; n++) begin : g_channel
			assign addr_hit[n] = (word.address == 4'(n)) ||
				(word.address == `ADDR_ALL_CHANNELS);
			assign power_select[n] = word.data[n];
			// Override channels see the load strobe as permanently low
			assign direct_update[n] = ~q.load_sync | q.override_mask[n];
		end
	endgenerate

	always_comb begin
		unique case (q.clear_select)
			CLEAR_TO_ZERO: clear_code = `CLEAR_CODE_ZERO;
			CLEAR_TO_MID: clear_code = `CLEAR_CODE_MID;
			CLEAR_TO_FULL: clear_code = `CLEAR_CODE_FULL;
			CLEAR_DISABLED: clear_code = `CLEAR_CODE_ZERO;
		endcase
	end

	always_comb begin
		d = q;
		powered_down = '0;
		d.clear_meta = clear_strobe_n_i;
		d.clear_sync = q.clear_meta;
		d.clear_last = q.clear_sync;
		d.load_meta = load_strobe_n_i;
		d.load_sync = q.load_meta;
		d.load_last = q.load_sync;
		d.select_meta = frame_sel_n_i;
		d.select_sync = q.select_meta;
		d.done_meta = done_toggle;
		d.done_sync = q.done_meta;
		d.done_last = q.done_sync;

		// Frame abandonment bookkeeping
		if (clear_fall && !q.select_sync) begin
			d.abort = 1'b1;
		end else if (frame_arrived || q.select_sync) begin
			d.abort = 1'b0;
		end

		// Hardware load falling copies the strobe-governed channels
		if (load_fall) begin
			for (int n = 0; n < `CHANNEL_COUNT; n++) begin
				if (!q.override_mask[n]) begin
					d.output_code[n] = q.input_code[n];
				end
			end
		end

		if (frame_execute) begin
			d.clear_state = 1'b0;
			unique case (word.command)
				`CMD_WRITE_INPUT: begin
					for (int n = 0; n < `CHANNEL_COUNT; n++) begin
						if (addr_hit[n]) begin
							d.input_code[n] = frame_code;
							if (direct_update[n]) begin
								d.output_code[n] = frame_code;
							end
						end
					end
				end
				`CMD_UPDATE_OUTPUT: begin
					for (int n = 0; n < `CHANNEL_COUNT; n++) begin
						if (addr_hit[n]) begin
							d.output_code[n] = q.input_code[n];
						end
					end
				end
				`CMD_WRITE_UPDATE_ALL: begin
					for (int n = 0; n < `CHANNEL_COUNT; n++) begin
						if (addr_hit[n]) begin
							d.input_code[n] = frame_code;
						end
					end
					for (int n = 0; n < `CHANNEL_COUNT; n++) begin
						d.output_code[n] = d.input_code[n];
					end
				end
				`CMD_WRITE_UPDATE_ONE: begin
					for (int n = 0; n < `CHANNEL_COUNT; n++) begin
						if (addr_hit[n]) begin
							d.input_code[n] = frame_code;
							d.output_code[n] = frame_code;
						end
					end
				end
				`CMD_POWER_CONTROL: begin
					// Output registers are left alone on entry to power-down
					for (int n = 0; n < `CHANNEL_COUNT; n++) begin
						if (power_select[n]) begin
							d.mode[n] = frame_mode;
							// Override channels see load low here too
							if (frame_mode == POWER_NORMAL &&
								q.mode[n] != POWER_NORMAL && direct_update[n]) begin
								d.output_code[n] = q.input_code[n];
							end
						end
					end
				end
				`CMD_CLEAR_SELECT: begin
					d.clear_select = clear_select_type'(
						word.data[`SELECT_FIELD_HI:`SELECT_FIELD_LO]);
				end
				`CMD_OVERRIDE_MASK: begin
					d.override_mask = word.data[`MASK_FIELD_HI:`MASK_FIELD_LO];
				end
				`CMD_REFERENCE_SETUP: begin
					d.reference_enable = word.data[`REF_ENABLE_BIT];
				end
				// Software reset and reserved codes only end the clear state in this block
				default: begin
				end
			endcase
		end

		// Clear is applied last so it wins over a load edge in the same cycle
		if (clear_fall && q.clear_select != CLEAR_DISABLED) begin
			for (int n = 0; n < `CHANNEL_COUNT; n++) begin
				d.input_code[n] = clear_code;
				d.output_code[n] = clear_code;
			end
			d.clear_state = 1'b1;
		end

		// Judged on the next modes so the reference follows the command in the same cycle
		for (int n = 0; n < `CHANNEL_COUNT; n++) begin
			powered_down[n] = (d.mode[n] != POWER_NORMAL);
		end
		// Partial power-down leaves the reference running
		d.reference_active = d.reference_enable & ~(&powered_down);
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			q <= '{
				input_code: {8{`RESET_CODE}},
				output_code: {8{`RESET_CODE}},
				mode: '{default: POWER_NORMAL},
				clear_select: clear_select_type'(`RESET_CLEAR_SELECT),
				override_mask: `RESET_OVERRIDE_MASK,
				reference_enable: `RESET_REFERENCE,
				reference_active: 1'b0,
				clear_state: 1'b0,
				abort: 1'b0,
				clear_meta: 1'b1,
				clear_sync: 1'b1,
				clear_last: 1'b1,
				load_meta: 1'b1,
				load_sync: 1'b1,
				load_last: 1'b1,
				select_meta: 1'b1,
				select_sync: 1'b1,
				done_meta: 1'b0,
				done_sync: 1'b0,
				done_last: 1'b0
			};
		end else begin
			q <= d;
		end
	end

	assign output_code_o = q.output_code;
	assign input_code_o = q.input_code;
	assign power_mode_o = q.mode;
	assign reference_on_o = q.reference_active;
	assign clear_active_o = q.clear_state;

endmodule : octal_dac_control

// ===== hw/dac_ctrl_params.svh
// Constants for the octal converter command decoder: codes, field positions, reset values
`ifndef DAC_CTRL_PARAMS_SVH
`define DAC_CTRL_PARAMS_SVH

`define CHANNEL_COUNT 8
`define FRAME_BITS 32
`define FRAME_COUNT_W 6

`define CMD_WRITE_INPUT 4'h0
`define CMD_UPDATE_OUTPUT 4'h1
`define CMD_WRITE_UPDATE_ALL 4'h2
`define CMD_WRITE_UPDATE_ONE 4'h3
`define CMD_POWER_CONTROL 4'h4
`define CMD_CLEAR_SELECT 4'h5
`define CMD_OVERRIDE_MASK 4'h6
`define CMD_SOFT_RESET 4'h7
`define CMD_REFERENCE_SETUP 4'h8

`define ADDR_ALL_CHANNELS 4'hF

`define CODE_FIELD_HI 19
`define CODE_FIELD_LO 4
`define MODE_FIELD_HI 9
`define MODE_FIELD_LO 8
`define SELECT_FIELD_HI 1
`define SELECT_FIELD_LO 0
`define MASK_FIELD_HI 7
`define MASK_FIELD_LO 0
`define REF_ENABLE_BIT 0

`define CLEAR_CODE_ZERO 16'h0000
`define CLEAR_CODE_MID 16'h8000
`define CLEAR_CODE_FULL 16'hFFFF

`define RESET_CODE 16'h0000
`define RESET_REFERENCE 1'h0
`define RESET_CLEAR_SELECT 2'h0
`define RESET_OVERRIDE_MASK 8'h00

`endif

// ===== hw/dac_ctrl_pkg.sv
// Types shared by the serial frame receiver and the converter control core
package dac_ctrl_pkg;

	typedef logic [15:0] code_type;

	typedef enum logic [1:0] {
		POWER_NORMAL = 2'h0,
		POWER_GND_1K = 2'h1,
		POWER_GND_100K = 2'h2,
		POWER_HIGH_Z = 2'h3
	} power_mode_type;

	typedef enum logic [1:0] {
		CLEAR_TO_ZERO = 2'h0,
		CLEAR_TO_MID = 2'h1,
		CLEAR_TO_FULL = 2'h2,
		CLEAR_DISABLED = 2'h3
	} clear_select_type;

	typedef struct packed {
		logic [3:0] ignored;
		logic [3:0] command;
		logic [3:0] address;
		logic [19:0] data;
	} frame_type;

	typedef struct packed {
		logic [30:0] shift;
		logic [5:0] count;
	} shift_state_type;

	typedef struct packed {
		frame_type word;
		logic done_toggle;
	} capture_state_type;

	typedef struct packed {
		code_type [7:0] input_code;
		code_type [7:0] output_code;
		power_mode_type [7:0] mode;
		clear_select_type clear_select;
		logic [7:0] override_mask;
		logic reference_enable;
		logic reference_active;
		logic clear_state;
		logic abort;
		logic clear_meta;
		logic clear_sync;
		logic clear_last;
		logic load_meta;
		logic load_sync;
		logic load_last;
		logic select_meta;
		logic select_sync;
		logic done_meta;
		logic done_sync;
		logic done_last;
	} core_state_type;

endpackage : dac_ctrl_pkg

// ===== hw/command_frame_receiver.sv
// Shift-clock domain: collects 32-bit command frames and hands complete ones over
`timescale 1ns/1ps
`include "dac_ctrl_params.svh"

module command_frame_receiver
	import dac_ctrl_pkg::*;
(
	input wire logic resetn_i,
	input wire logic shift_clk_i,
	input wire logic frame_sel_n_i,
	input wire logic serial_data_i,
	output frame_type word_o,
	output logic done_toggle_o
);

	shift_state_type shift_q;
	shift_state_type shift_d;
	capture_state_type cap_q;
	capture_state_type cap_d;
	logic frame_arst_n;

	// Frame select high wipes any partial frame even with the shift clock stopped
	assign frame_arst_n = resetn_i & ~frame_sel_n_i;

	always_comb begin
		shift_d = shift_q;
		cap_d = cap_q;
		if (shift_q.count < 6'(`FRAME_BITS)) begin
			shift_d.shift = {shift_q.shift[29:0], serial_data_i};
			shift_d.count = shift_q.count + 6'h01;
		end
		// The last bit completes the word on the 32nd falling edge
		if (shift_q.count == 6'(`FRAME_BITS - 1)) begin
			cap_d.word = {shift_q.shift, serial_data_i};
			cap_d.done_toggle = ~cap_q.done_toggle;
		end
	end

	always_ff @(negedge shift_clk_i or negedge frame_arst_n) begin
		if (!frame_arst_n) begin
			shift_q <= '0;
		end else begin
			shift_q <= shift_d;
		end
	end

	// Captured word and toggle survive frame select so the core can read them after it rises
	always_ff @(negedge shift_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cap_q <= '0;
		end else begin
			cap_q <= cap_d;
		end
	end

	assign word_o = cap_q.word;
	assign done_toggle_o = cap_q.done_toggle;

endmodule : command_frame_receiver

// ===== tb/octal_dac_control_properties.sv
// Checker for the octal converter control core
`timescale 1ns/1ps
module octal_dac_control_properties
	import dac_ctrl_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic frame_sel_n_i,
	input wire logic load_strobe_n_i,
	input wire logic clear_strobe_n_i,
	input code_type [7:0] output_code_o,
	input code_type [7:0] input_code_o,
	input power_mode_type [7:0] power_mode_o,
	input wire logic reference_on_o,
	input wire logic clear_active_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	logic [3:0] sel_gap_q;
	logic [3:0] clr_gap_q;
	logic [7:0] down;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			down[i] = power_mode_o[i] != POWER_NORMAL;
		end
	end
	// Saturating ages of the last low sample, so effects can be traced to a cause
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sel_gap_q <= 4'hF;
			clr_gap_q <= 4'hF;
		end else begin
			sel_gap_q <= !frame_sel_n_i ? 4'h0 : sel_gap_q + 4'(sel_gap_q != 4'hF);
			clr_gap_q <= !clear_strobe_n_i ? 4'h0 : clr_gap_q + 4'(clr_gap_q != 4'hF);
		end
	end
	chk_frame_quiet: assert property (
		(frame_sel_n_i && load_strobe_n_i && clear_strobe_n_i)[*8]
		|=> $stable(input_code_o) && $stable(output_code_o) && $stable(power_mode_o))
		else $error("registers moved while idle");
	chk_mode_hold: assert property (
		$changed(power_mode_o) && load_strobe_n_i && $past(load_strobe_n_i, 6)
		|-> $stable(output_code_o)) else $error("power change moved output");
	chk_load_copy: assert property (
		$fell(load_strobe_n_i) && clear_strobe_n_i && sel_gap_q > 4'h8
		|-> ##[3:6] output_code_o == input_code_o) else $error("load did not copy");
	chk_clear_exit: assert property ($fell(clear_active_o) |-> sel_gap_q < 4'h9)
		else $error("clear left without frame");
	chk_clear_rise: assert property ($rose(clear_active_o) |-> clr_gap_q < 4'h7)
		else $error("clear without strobe");
	chk_clear_same: assert property (
		clear_active_o && $past(clear_active_o) |-> input_code_o == output_code_o)
		else $error("clear codes differ");
	chk_clear_code: assert property ($rose(clear_active_o) |=>
		output_code_o[0] inside {16'h0000, 16'h8000, 16'hFFFF}) else $error("bad clear code");
	chk_ref_gate: assert property (&down && &$past(down) |-> !reference_on_o)
		else $error("reference on with all down");
	cover property ($rose(clear_active_o));
	cover property ($fell(load_strobe_n_i) ##6 output_code_o == input_code_o);
	cover property ($changed(power_mode_o));
endmodule : octal_dac_control_properties

bind octal_dac_control octal_dac_control_properties chk (.clk_i(clk_i), .resetn_i(resetn_i),
	.frame_sel_n_i(frame_sel_n_i), .load_strobe_n_i(load_strobe_n_i),
	.clear_strobe_n_i(clear_strobe_n_i), .output_code_o(output_code_o),
	.input_code_o(input_code_o), .power_mode_o(power_mode_o),
	.reference_on_o(reference_on_o), .clear_active_o(clear_active_o));

// ===== tb/serial_host_model.sv
// Host model driving command frames over the three-wire serial port
`timescale 1ns/1ps
module serial_host_model (
	output logic shift_clk_o,
	output logic frame_sel_n_o,
	output logic serial_data_o
);
	initial begin
		shift_clk_o = 1'b1;
		frame_sel_n_o = 1'b1;
		serial_data_o = 1'b0;
	end
	// Fewer than 32 bits makes an aborted frame; the clock stands still between frames
	task automatic send(input logic [31:0] word, input int bits);
		#7 frame_sel_n_o = 1'b0;
		for (int i = 31; i > 31 - bits; i--) begin
			serial_data_o = word[i];
			#15 shift_clk_o = 1'b0;
			#15 shift_clk_o = 1'b1;
		end
		#5 frame_sel_n_o = 1'b1;
		// Released line shows the inverse so a stale bit cannot pass for data
		serial_data_o = ~serial_data_o;
		#40;
	endtask : send
endmodule : serial_host_model

// ===== tb/octal_dac_control_tb.sv
// Self-checking bench for the octal converter control core
`timescale 1ns/1ps
module octal_dac_control_tb
	import dac_ctrl_pkg::*;
;
	logic clk_i, resetn_i, load_n, clr_n, ref_on, clr_act;
	wire logic sclk, sel_n, sdat;
	code_type [7:0] out_code, in_code;
	power_mode_type [7:0] mode;
	int error_cnt, check_count;
	logic [127:0] v;

	serial_host_model host (.shift_clk_o(sclk), .frame_sel_n_o(sel_n), .serial_data_o(sdat));
	octal_dac_control DUT (.clk_i(clk_i), .resetn_i(resetn_i), .shift_clk_i(sclk),
		.frame_sel_n_i(sel_n), .serial_data_i(sdat), .load_strobe_n_i(load_n),
		.clear_strobe_n_i(clr_n), .output_code_o(out_code), .input_code_o(in_code),
		.power_mode_o(mode), .reference_on_o(ref_on), .clear_active_o(clr_act));

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_i);
	endtask : wait_clk
	task automatic chk(input string n, input logic [127:0] e, input logic [127:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic frame(input logic [3:0] c, input logic [3:0] a, input logic [19:0] d);
		host.send({4'hA, c, a, d}, 32);
		wait_clk(8);
	endtask : frame
	task automatic set_load(input logic x);
		@(posedge clk_i) load_n <= x;
		wait_clk(8);
	endtask : set_load
	task automatic pulse_clear;
		@(posedge clk_i) clr_n <= 1'b0;
		wait_clk(8);
		clr_n <= 1'b1;
		wait_clk(8);
	endtask : pulse_clear
	task automatic results;
		if (error_cnt == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : results

	task automatic t_load;
		v = {32'h0, 16'h1111, 16'h0F0F, 16'h9ABC, 16'h5678, 16'h1234, 16'h0};
		frame(4'h0, 4'h1, {16'h1234, 4'hF});
		chk("out1", 16'h1234, out_code[1]);
		set_load(1'b1);
		frame(4'h0, 4'h2, {16'h5678, 4'h0});
		chk("in2", 16'h5678, in_code[2]);
		chk("out2", 16'h0, out_code[2]);
		set_load(1'b0);
		chk("out2 load", 16'h5678, out_code[2]);
		set_load(1'b1);
		frame(4'h6, 4'h9, 20'hFFF08);
		frame(4'h0, 4'h3, {16'h9ABC, 4'h0});
		chk("out3", 16'h9ABC, out_code[3]);
		frame(4'h0, 4'h4, {16'h0F0F, 4'h0});
		chk("out4", 16'h0, out_code[4]);
		frame(4'h2, 4'h5, {16'h1111, 4'h0});
		chk("out all", v, out_code);
		frame(4'h6, 4'h0, 20'h0);
		set_load(1'b0);
	endtask : t_load

	task automatic t_abort;
		host.send({12'h006, 16'hDEAD, 4'h0}, 20);
		wait_clk(8);
		chk("in6", 16'h0, in_code[6]);
		frame(4'h0, 4'h6, {16'hBEEF, 4'h0});
		v[111:96] = 16'hBEEF;
		chk("out6", v, out_code);
	endtask : t_abort

	task automatic t_power;
		logic [15:0] em;
		set_load(1'b1);
		for (int m = 1; m < 4; m++) begin
			frame(4'h4, 4'hE, {10'h2AA, 2'(m), 8'hA5});
			for (int i = 0; i < 8; i++) begin
				em[2*i+:2] = 8'hA5 >> i & 8'h01 ? 2'(m) : 2'h0;
			end
			chk("mode", em, mode);
			chk("out kept", v, out_code);
		end
		frame(4'h0, 4'h0, {16'h4444, 4'h0});
		frame(4'h4, 4'h0, {12'h0, 8'h01});
		chk("mode0", 2'h0, mode[0]);
		chk("out0 up", 16'h0, out_code[0]);
		frame(4'h4, 4'h0, {12'h0, 8'hFF});
		set_load(1'b0);
		v[15:0] = 16'h4444;
		chk("out load", v, out_code);
	endtask : t_power

	task automatic t_ref;
		frame(4'h8, 4'h3, 20'hFFFF1);
		chk("ref on", 1'b1, ref_on);
		frame(4'h4, 4'h0, {12'h0, 8'hFF} | 20'h200);
		chk("ref all down", 1'b0, ref_on);
		frame(4'h4, 4'h0, {12'h0, 8'hFF});
		chk("ref up", 1'b1, ref_on);
		frame(4'h8, 4'h0, 20'hFFFFE);
		chk("ref off", 1'b0, ref_on);
	endtask : t_ref

	task automatic t_clear;
		logic [15:0] e;
		logic [15:0] cc [4];
		cc = '{16'h0000, 16'h8000, 16'hFFFF, 16'h2222};
		pulse_clear;
		chk("default", 128'h0, out_code);
		for (int s = 0; s < 4; s++) begin
			frame(4'h5, 4'hA, {18'h3FFFF, 2'(s)});
			chk("left", 1'b0, clr_act);
			frame(4'h0, 4'hF, {16'h2222, 4'h0});
			pulse_clear;
			e = cc[s];
			chk("in", {8{e}}, in_code);
			chk("out", {8{e}}, out_code);
			chk("active", s != 3, clr_act);
		end
		frame(4'h5, 4'h0, 20'h0);
		pulse_clear;
		fork
			host.send({12'h007, 16'h3333, 4'h0}, 32);
		join_none
		wait_clk(100);
		pulse_clear;
		wait fork;
		wait_clk(8);
		chk("in7", 16'h0, in_code[7]);
		chk("held", 1'b1, clr_act);
		frame(4'h0, 4'h7, {16'h3333, 4'h0});
		chk("exit", 1'b0, clr_act);
		chk("out7", 16'h3333, out_code[7]);
	endtask : t_clear

	initial begin
		resetn_i = 1'b0;
		load_n = 1'b0;
		clr_n = 1'b1;
		error_cnt = 0;
		check_count = 0;
		wait_clk(5);
		resetn_i <= 1'b1;
		wait_clk(3);
		chk("reset out", 128'h0, out_code);
		chk("reset in", 128'h0, in_code);
		chk("reset state", 128'h0, {mode, ref_on, clr_act});
		t_load;
		t_abort;
		t_power;
		t_ref;
		t_clear;
		results;
	end

	initial begin
		wait_clk(30000);
		error_cnt++;
		results;
	end
endmodule : octal_dac_control_tb
